// File: pcb_config_header.sv
// primary configuration header: identity and primary command register
//
// Behaviour
// [R1] each low byte enable selects one byte of the addressed dword
// [R2] reserved fields and registers read as zero and are read-only
// [R3] dword 0x00 bits 15:0 hold the fixed maker identification
// [R4] dword 0x00 bits 31:16 hold the fixed part identification
// [R5] command bit 0 gates primary i/o response; resets to 0
// [R6] command bit 1 gates primary memory response; resets to 0
// [R7] command bit 2 gates secondary claims and primary initiation; configuration claims and initiations bypass it
// [R8] command bit 3 reads zero; special cycles are ignored
// [R9] command bit 4 reads zero; invalidate writes only forwarded
// [R10] palette write: i/o write, low bits 3c6/3c8/3c9, top half zero
// [R11] command bit 5 positively decodes and forwards palette writes
// [R12] bit 6 clear: no parity-error drive, no report, no address serr
// [R13] bit 6 set: parity-error drive, report bit, address serr allowed
// [R14] command bit 7 reads zero; no address or data stepping
// [R15] system-error pin driven only while bit 8 is set; resets 0
// [R16] command bit 9 reads zero; no fast back-to-back generation
// [R17] software programs the command register before relying on it
// [R18] only type 0 configuration cycles reach it; bits 7:2 pick dword
// [R19] writes to read-only and reserved bits are ignored
`timescale 1ns/1ps
`include "pcb_params.svh"

module pcb_config_header #(
  parameter logic [15:0] MAKER_ID = 16'h5a5a, // arbitrary value
  parameter logic [15:0] PART_ID = 16'ha5a5, // arbitrary value
  parameter int ADDR_W = 32
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  // configuration data phase, one cycle per dword
  input wire logic i_cfg_valid,
  input wire logic i_cfg_type0,
  input wire logic i_cfg_write,
  input wire logic [5:0] i_cfg_dword,
  input wire logic [3:0] i_primary_cmd_byte_enable_n,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [15:0] i_primary_status,
  output logic o_cfg_done,
  output logic o_cfg_hit,
  output logic [31:0] o_cfg_rdata,
  output logic [15:0] o_primary_command,
  // primary-side target decode
  input wire logic i_pri_txn_valid,
  input wire logic i_pri_txn_io,
  input wire logic i_pri_txn_write,
  input wire logic [ADDR_W-1:0] i_pri_txn_addr,
  input wire logic i_pri_in_io_window,
  input wire logic i_pri_in_mem_window,
  output logic o_pri_claim_io,
  output logic o_pri_claim_mem,
  output logic o_pri_claim_vga,
  // secondary-side decode and primary initiation
  input wire logic i_sec_txn_valid,
  input wire logic i_sec_txn_config,
  input wire logic i_sec_txn_hit,
  input wire logic i_pri_init_req,
  input wire logic i_pri_init_config,
  output logic o_sec_claim,
  output logic o_pri_init_grant,
  // error reporting on the primary bus
  input wire logic i_data_parity_err,
  input wire logic i_pri_bus_master,
  input wire logic i_perr_seen,
  input wire logic i_addr_parity_err,
  input wire logic i_serr_event,
  output logic o_primary_parity_error_n_out,
  output logic o_primary_parity_error_n_oe_n,
  output logic o_primary_system_error_n_out,
  output logic o_primary_system_error_n_oe_n,
  output logic o_data_parity_reported_set,
  output logic o_system_error_signaled_set
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  pcb_pkg::pcb_cfg_state_t cfg_state;
  pcb_pkg::pcb_cfg_state_t next_cfg_state;
  pcb_pkg::pcb_half_t command;
  pcb_pkg::pcb_half_t next_command;
  pcb_pkg::pcb_dword_t read_word;
  pcb_pkg::pcb_dword_t byte_mask;
  pcb_pkg::pcb_dword_t masked_wdata;
  pcb_pkg::pcb_half_t write_bits;
  logic cfg_take;
  logic cfg_write_cmd;
  logic offset_known;
  logic palette_write;

  logic io_en;
  logic mem_en;
  logic master_en;
  logic vga_snoop;
  logic parity_resp;
  logic serr_en;

  ////////////////////////////////////////////////////////////////////////////
  // configuration access decode
  assign cfg_take = i_cfg_valid && i_cfg_type0; // R18
  assign offset_known = (i_cfg_dword == `PCB_OFS_IDENT) ||
                        (i_cfg_dword == `PCB_OFS_CMD_STAT);

  // a low enable selects its byte lane
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byte_mask[8*b +: 8] = {8{~i_primary_cmd_byte_enable_n[b]}}; // R1
    end
  end

  assign masked_wdata = i_cfg_wdata & byte_mask; // R1
  assign cfg_write_cmd = cfg_take && i_cfg_write &&
                         (i_cfg_dword == `PCB_OFS_CMD_STAT); // R18

  // read-only and reserved bits keep their value
  assign write_bits = byte_mask[15:0] & `PCB_CMD_WRITE_MASK; // R19

  always_comb begin
    next_command = command;
    if (cfg_write_cmd) begin
      next_command = (command & ~write_bits) |
                     (masked_wdata[15:0] & write_bits); // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // primary command register
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      command <= `PCB_CMD_RESET; // R5 R6 R15
    end else begin
      command <= next_command;
    end
  end

  assign io_en = command[`PCB_CMD_IO_EN];
  assign mem_en = command[`PCB_CMD_MEM_EN];
  assign master_en = command[`PCB_CMD_MASTER_EN];
  assign vga_snoop = command[`PCB_CMD_VGA_SNOOP];
  assign parity_resp = command[`PCB_CMD_PARITY_RESP];
  assign serr_en = command[`PCB_CMD_SERR_EN];
  assign o_primary_command = command;

  ////////////////////////////////////////////////////////////////////////////
  // read data assembly
  always_comb begin
    read_word = '0; // R2
    if (i_cfg_dword == `PCB_OFS_IDENT) begin
      read_word[`PCB_MAKER_LSB +: 16] = MAKER_ID; // R3
      read_word[`PCB_PART_LSB +: 16] = PART_ID; // R4
    end else if (i_cfg_dword == `PCB_OFS_CMD_STAT) begin
      // bits 3 4 7 9 and 15:10 are never set in the register
      read_word[15:0] = command; // R8 R9 R14 R16 R2
      read_word[`PCB_STATUS_LSB +: 16] = i_primary_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer sequencing
  always_comb begin
    case (cfg_state)
      pcb_pkg::PCB_IDLE: begin
        next_cfg_state = cfg_take ? pcb_pkg::PCB_ANSWER : pcb_pkg::PCB_IDLE;
      end
      pcb_pkg::PCB_ANSWER: begin
        next_cfg_state = cfg_take ? pcb_pkg::PCB_ANSWER : pcb_pkg::PCB_IDLE;
      end
      default: begin
        next_cfg_state = pcb_pkg::PCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      cfg_state <= pcb_pkg::PCB_IDLE;
    end else begin
      cfg_state <= next_cfg_state;
    end
  end

  assign o_cfg_done = (cfg_state == pcb_pkg::PCB_ANSWER);

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_cfg_rdata <= 32'h0000_0000;
      o_cfg_hit <= 1'b0;
    end else if (cfg_take) begin
      o_cfg_hit <= offset_known;
      if (i_cfg_write) begin
        o_cfg_rdata <= 32'h0000_0000;
      end else begin
        o_cfg_rdata <= read_word & byte_mask; // R1
      end
    end else begin
      o_cfg_hit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // primary target claims
  pcb_vga_palette_decode #(
    .ADDR_W(ADDR_W)
  ) u_palette (
    .i_addr(i_pri_txn_addr),
    .i_io_write(i_pri_txn_io && i_pri_txn_write),
    .o_palette_write(palette_write)
  );

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_pri_claim_io <= 1'b0;
      o_pri_claim_mem <= 1'b0;
      o_pri_claim_vga <= 1'b0;
    end else begin
      o_pri_claim_io <= i_pri_txn_valid && i_pri_txn_io &&
                        io_en && i_pri_in_io_window; // R5
      o_pri_claim_mem <= i_pri_txn_valid && !i_pri_txn_io &&
                         mem_en && i_pri_in_mem_window; // R6
      // outside the window a palette write needs snooping on
      o_pri_claim_vga <= i_pri_txn_valid && palette_write && vga_snoop; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // secondary claims and primary initiation
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_sec_claim <= 1'b0;
      o_pri_init_grant <= 1'b0;
    end else begin
      // configuration forwarding ignores the master enable
      o_sec_claim <= i_sec_txn_valid && i_sec_txn_hit &&
                     (master_en || i_sec_txn_config); // R7
      o_pri_init_grant <= i_pri_init_req &&
                          (master_en || i_pri_init_config); // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parity error pin
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_primary_parity_error_n_out <= 1'b1;
      o_primary_parity_error_n_oe_n <= 1'b1;
    end else if (i_data_parity_err && parity_resp) begin
      o_primary_parity_error_n_out <= 1'b0; // R13
      o_primary_parity_error_n_oe_n <= 1'b0; // R13
    end else begin
      o_primary_parity_error_n_out <= 1'b1; // R12
      o_primary_parity_error_n_oe_n <= 1'b1; // R12
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_data_parity_reported_set <= 1'b0;
    end else begin
      o_data_parity_reported_set <= i_pri_bus_master && i_perr_seen &&
                                    parity_resp; // R12 R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system error pin
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_primary_system_error_n_out <= 1'b1;
      o_primary_system_error_n_oe_n <= 1'b1;
      o_system_error_signaled_set <= 1'b0;
    end else if (serr_en && (i_serr_event ||
                 (i_addr_parity_err && parity_resp))) begin // R12 R13 R15
      o_primary_system_error_n_out <= 1'b0; // R15
      o_primary_system_error_n_oe_n <= 1'b0; // R15
      o_system_error_signaled_set <= 1'b1;
    end else begin
      o_primary_system_error_n_out <= 1'b1;
      o_primary_system_error_n_oe_n <= 1'b1; // R15
      o_system_error_signaled_set <= 1'b0;
    end
  end

endmodule : pcb_config_header

// File: pcb_params.svh
// offsets, field positions, reset values and decode constants
`ifndef PCB_PARAMS_SVH
`define PCB_PARAMS_SVH

`define PCB_OFS_IDENT 6'h00
`define PCB_OFS_CMD_STAT 6'h01

`define PCB_MAKER_LSB 0
`define PCB_PART_LSB 16
`define PCB_STATUS_LSB 16

`define PCB_CMD_IO_EN 0
`define PCB_CMD_MEM_EN 1
`define PCB_CMD_MASTER_EN 2
`define PCB_CMD_SPECIAL 3
`define PCB_CMD_MWI 4
`define PCB_CMD_VGA_SNOOP 5
`define PCB_CMD_PARITY_RESP 6
`define PCB_CMD_WAIT_CTL 7
`define PCB_CMD_SERR_EN 8
`define PCB_CMD_FAST_B2B 9

`define PCB_CMD_RESET 16'h0000
`define PCB_CMD_WRITE_MASK 16'h0167

`define PCB_VGA_PAL_MASK 10'h3c6
`define PCB_VGA_PAL_READ 10'h3c7
`define PCB_VGA_PAL_WRITE 10'h3c8
`define PCB_VGA_PAL_DATA 10'h3c9

`endif

// File: pcb_pkg.sv
// types shared by the primary configuration header logic
package pcb_pkg;

  typedef logic [31:0] pcb_dword_t;
  typedef logic [15:0] pcb_half_t;
  typedef logic [5:0] pcb_offset_t;

  typedef enum logic [1:0] {
    PCB_IDLE,
    PCB_ANSWER
  } pcb_cfg_state_t;

endpackage : pcb_pkg

// File: pcb_vga_palette_decode.sv
// decode of vga palette write addresses on the primary bus
`timescale 1ns/1ps
`include "pcb_params.svh"

module pcb_vga_palette_decode #(
  parameter int ADDR_W = 32
) (
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_io_write,
  output logic o_palette_write
);

  logic [9:0] low_bits;
  logic upper_zero;
  logic low_match;

  assign low_bits = i_addr[9:0];
  // bits 15:10 are not decoded
  assign upper_zero = (i_addr[ADDR_W-1:16] == '0); // R10
  assign low_match = (low_bits == `PCB_VGA_PAL_MASK) ||
                     (low_bits == `PCB_VGA_PAL_WRITE) ||
                     (low_bits == `PCB_VGA_PAL_DATA); // R10
  assign o_palette_write = i_io_write && upper_zero && low_match; // R10

endmodule : pcb_vga_palette_decode

// File: pcb_config_header_sva.sv
// port assertions for the primary configuration header
`timescale 1ns/1ps
module pcb_config_header_sva (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_cfg_valid,
  input wire logic i_cfg_type0,
  input wire logic i_pri_txn_valid,
  input wire logic i_pri_txn_io,
  input wire logic i_pri_in_io_window,
  input wire logic i_pri_in_mem_window,
  input wire logic o_cfg_done,
  input wire logic [15:0] o_primary_command,
  input wire logic o_pri_claim_io,
  input wire logic o_pri_claim_mem,
  input wire logic o_primary_parity_error_n_oe_n,
  input wire logic o_primary_system_error_n_out,
  input wire logic o_primary_system_error_n_oe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence cfg_req;
    i_cfg_valid && i_cfg_type0;
  endsequence
  sequence serr_drive;
    !o_primary_system_error_n_oe_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  req_done_a: assert property (cfg_req |=> o_cfg_done)
    else $error("no done after config request");
  stray_done_a: assert property (!(i_cfg_valid && i_cfg_type0) |=> !o_cfg_done)
    else $error("done without a type 0 request");
  ro_bits_a: assert property ((o_primary_command & 16'hfe98) == 16'h0000)
    else $error("read-only command bit set");
  cmd_reset_a: assert property ($rose(i_rstn) |-> o_primary_command == 16'h0000)
    else $error("command not zero after reset");
  io_claim_a: assert property (o_pri_claim_io == $past(i_pri_txn_valid
    && i_pri_txn_io && i_pri_in_io_window && o_primary_command[0]))
    else $error("io claim mismatch");
  mem_claim_a: assert property (o_pri_claim_mem == $past(i_pri_txn_valid
    && !i_pri_txn_io && i_pri_in_mem_window && o_primary_command[1]))
    else $error("memory claim mismatch");
  serr_gate_a: assert property (serr_drive |-> $past(o_primary_command[8]))
    else $error("system error driven while disabled");
  serr_low_a: assert property (serr_drive |-> !o_primary_system_error_n_out)
    else $error("system error driven high");
  perr_gate_a: assert property (!o_primary_parity_error_n_oe_n
    |-> $past(o_primary_command[6]))
    else $error("parity error driven while disabled");
endmodule : pcb_config_header_sva

bind pcb_config_header pcb_config_header_sva u_sva (
  .i_clock, .i_rstn, .i_cfg_valid, .i_cfg_type0, .i_pri_txn_valid,
  .i_pri_txn_io, .i_pri_in_io_window, .i_pri_in_mem_window, .o_cfg_done,
  .o_primary_command, .o_pri_claim_io, .o_pri_claim_mem,
  .o_primary_parity_error_n_oe_n, .o_primary_system_error_n_out,
  .o_primary_system_error_n_oe_n
);

// File: pcb_cfg_master.sv
// configuration master on the primary bus
`timescale 1ns/1ps
module pcb_cfg_master (
  input wire logic i_clock,
  input wire logic i_done,
  input wire logic i_hit,
  input wire logic [31:0] i_rdata,
  output logic o_valid,
  output logic o_type0,
  output logic o_write,
  output logic [5:0] o_dword,
  output logic [3:0] o_be_n,
  output logic [31:0] o_wdata
);
  initial begin
    {o_valid, o_type0, o_write} = 3'h0;
    o_dword = 6'h3f;
    o_be_n = 4'hf;
    o_wdata = 32'h0;
  end
  // one data phase, answer taken one cycle after it
  task automatic access(input logic t0, input logic w,
      input logic [5:0] d, input logic [3:0] be, input logic [31:0] wd,
      output logic dn, output logic ht, output logic [31:0] rd);
    @(posedge i_clock);
    o_valid <= 1'b1;
    o_type0 <= t0;
    o_write <= w;
    o_dword <= d;
    o_be_n <= be;
    o_wdata <= wd;
    @(posedge i_clock);
    o_valid <= 1'b0;
    o_be_n <= ~be;
    o_wdata <= ~wd;
    // answer stands between the two edges; look at it mid-cycle
    @(negedge i_clock);
    dn = i_done;
    ht = i_hit;
    rd = i_rdata;
  endtask : access
endmodule : pcb_cfg_master

// File: pcb_config_header_tb.sv
// self-checking bench for the primary configuration header
`timescale 1ns/1ps
module pcb_config_header_tb;
  localparam logic [15:0] MAKER = 16'h3c3c; // arbitrary value
  localparam logic [15:0] PART = 16'hc3c3; // arbitrary value
  localparam logic [15:0] STATUS = 16'h1234;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_cfg_valid, i_cfg_type0, i_cfg_write, o_cfg_done, o_cfg_hit;
  logic [5:0] i_cfg_dword;
  logic [3:0] i_primary_cmd_byte_enable_n, err_in;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, i_pri_txn_addr;
  logic [15:0] o_primary_command;
  logic i_pri_txn_valid, i_pri_txn_io, i_pri_txn_write, i_sec_txn_valid;
  logic i_pri_in_io_window, i_pri_in_mem_window, i_sec_txn_hit;
  logic i_sec_txn_config, i_pri_init_req, i_pri_init_config;
  logic o_pri_claim_io, o_pri_claim_mem, o_pri_claim_vga, o_sec_claim;
  logic o_pri_init_grant, o_data_parity_reported_set;
  logic o_system_error_signaled_set;
  logic o_primary_parity_error_n_out, o_primary_parity_error_n_oe_n;
  logic o_primary_system_error_n_out, o_primary_system_error_n_oe_n;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  pcb_config_header #(.MAKER_ID(MAKER), .PART_ID(PART)) u_dut (
    .i_clock, .i_rstn, .i_cfg_valid, .i_cfg_type0, .i_cfg_write,
    .i_cfg_dword, .i_primary_cmd_byte_enable_n, .i_cfg_wdata,
    .i_primary_status(STATUS), .o_cfg_done, .o_cfg_hit, .o_cfg_rdata,
    .o_primary_command, .i_pri_txn_valid, .i_pri_txn_io, .i_pri_txn_write,
    .i_pri_txn_addr, .i_pri_in_io_window, .i_pri_in_mem_window,
    .o_pri_claim_io, .o_pri_claim_mem, .o_pri_claim_vga, .i_sec_txn_valid,
    .i_sec_txn_config, .i_sec_txn_hit, .i_pri_init_req, .i_pri_init_config,
    .o_sec_claim, .o_pri_init_grant, .i_data_parity_err(err_in[0]),
    .i_pri_bus_master(1'b1), .i_perr_seen(err_in[1]),
    .i_addr_parity_err(err_in[2]), .i_serr_event(err_in[3]),
    .o_primary_parity_error_n_out, .o_primary_parity_error_n_oe_n,
    .o_primary_system_error_n_out, .o_primary_system_error_n_oe_n,
    .o_data_parity_reported_set, .o_system_error_signaled_set
  );
  pcb_cfg_master u_master (
    .i_clock, .i_done(o_cfg_done), .i_hit(o_cfg_hit), .i_rdata(o_cfg_rdata),
    .o_valid(i_cfg_valid), .o_type0(i_cfg_type0), .o_write(i_cfg_write),
    .o_dword(i_cfg_dword), .o_be_n(i_primary_cmd_byte_enable_n),
    .o_wdata(i_cfg_wdata)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cfg(input logic t0, input logic w, input logic [5:0] d,
      input logic [3:0] be, input logic [31:0] wd, input logic [1:0] dh,
      output logic [31:0] rd);
    logic dn;
    logic ht;
    u_master.access(t0, w, d, be, wd, dn, ht, rd);
    chk({30'h0, dn, ht}, {30'h0, dh});
  endtask : cfg
  task automatic t_regs;
    logic [31:0] rd;
    cfg(1, 0, 6'h01, 4'h0, 0, 2'b11, rd);
    chk(rd, {STATUS, 16'h0000});
    cfg(1, 1, 6'h00, 4'h0, '1, 2'b11, rd);
    cfg(1, 0, 6'h00, 4'h0, 0, 2'b11, rd);
    chk(rd, {PART, MAKER});
    cfg(1, 0, 6'h00, 4'hc, 0, 2'b11, rd);
    chk(rd, {16'h0000, MAKER});
    cfg(1, 1, 6'h01, 4'h0, '1, 2'b11, rd);
    cfg(1, 0, 6'h01, 4'h0, 0, 2'b11, rd);
    chk(rd, {STATUS, 16'h0167});
    cfg(0, 1, 6'h01, 4'h0, 0, 2'b00, rd);
    cfg(1, 1, 6'h01, 4'he, 0, 2'b11, rd);
    cfg(1, 0, 6'h01, 4'h0, 0, 2'b11, rd);
    chk(rd, {STATUS, 16'h0100});
    cfg(1, 0, 6'h05, 4'h0, 0, 2'b10, rd);
    chk(rd, 32'h0);
    $display("registers test done");
  endtask : t_regs
  task automatic t_decode(input logic [15:0] c);
    logic [31:0] ad [5] = '{32'h3c6, 32'hffc8, 32'h3c9, 32'h3c7, 32'h103c6};
    logic [31:0] rd;
    cfg(1, 1, 6'h01, 4'hc, {16'h0, c}, 2'b11, rd);
    for (int k = 0; k < 6; k++) begin
      @(posedge i_clock);
      {i_pri_txn_valid, i_sec_txn_valid, i_pri_init_req} <= 3'h7;
      {i_pri_txn_write, i_pri_in_io_window, i_pri_in_mem_window} <= 3'h7;
      i_sec_txn_hit <= 1'b1;
      i_pri_txn_io <= k < 5;
      i_pri_txn_addr <= k < 5 ? ad[k] : 32'h3c8;
      i_sec_txn_config <= k == 5;
      i_pri_init_config <= k == 5;
      @(posedge i_clock);
      {i_pri_txn_valid, i_sec_txn_valid, i_pri_init_req} <= 3'h0;
      @(negedge i_clock);
      chk({27'h0, o_pri_claim_io, o_pri_claim_mem, o_pri_claim_vga,
        o_sec_claim, o_pri_init_grant}, {27'h0, c[0] && k < 5,
        c[1] && k == 5, c[5] && k < 3, c[2] || k == 5,
        c[2] || k == 5});
    end
    $display("decode test done");
  endtask : t_decode
  task automatic t_err(input logic [15:0] c);
    logic [31:0] rd;
    logic p;
    logic r;
    logic s;
    cfg(1, 1, 6'h01, 4'hc, {16'h0, c}, 2'b11, rd);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      err_in <= 4'h1 << k;
      @(posedge i_clock);
      err_in <= 4'h0;
      @(negedge i_clock);
      p = c[6] && k == 0;
      r = c[6] && k == 1;
      s = c[8] && (k == 3 || (k == 2 && c[6]));
      chk({26'h0, ~o_primary_parity_error_n_oe_n,
        ~o_primary_parity_error_n_out, ~o_primary_system_error_n_oe_n,
        ~o_primary_system_error_n_out, o_data_parity_reported_set,
        o_system_error_signaled_set}, {26'h0, p, p, s, s, r, s});
    end
    $display("error test done");
  endtask : t_err
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {i_pri_txn_valid, i_pri_txn_io, i_pri_txn_write, i_sec_txn_valid} = '0;
    {i_pri_in_io_window, i_pri_in_mem_window, i_sec_txn_hit} = '0;
    {i_sec_txn_config, i_pri_init_req, i_pri_init_config} = '0;
    i_pri_txn_addr = '0;
    err_in = '0;
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    t_regs();
    t_decode(16'h0000);
    t_decode(16'h0167);
    t_decode(16'h0022);
    t_err(16'h0000);
    t_err(16'h0100);
    t_err(16'h0140);
    t_err(16'h0040);
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    t_regs();
    summarize();
  end
endmodule : pcb_config_header_tb
